// ==== verilog/wdl_pkg.sv ====
/*
  Constants, field layout and carrier types for the watchdog with flash lock.
  Assumes an 8-bit special-function-register port on the core clock.
*/
package wdl_pkg;
  // ----------------------------------------------------------------------
  // addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0]  WDL_CTRL_ADDR       = 8'hc0;
  localparam logic [7:0]  WDL_KEY_ADDR        = 8'hbb;
  localparam logic [15:0] WDL_FLASH_LOCK_ADDR = 16'h3ffa;
  localparam logic [15:0] WDL_FLASH_PROT_FIRST = 16'h3ffb;
  localparam logic [15:0] WDL_FLASH_PROT_LAST  = 16'h3fff;
  localparam logic [2:0]  WDL_PROT_LAST_STEP   =
    3'(WDL_FLASH_PROT_LAST - WDL_FLASH_PROT_FIRST);

  // ----------------------------------------------------------------------
  // control register fields and reset values
  // ----------------------------------------------------------------------
  localparam int WDL_BIT_UNLOCK = 0;
  localparam int WDL_BIT_EN     = 1;
  localparam int WDL_BIT_FLAG   = 2;
  localparam int WDL_BIT_RESP   = 3;
  localparam int WDL_LOCK_BIT   = 7;
  localparam logic [3:0] WDL_PRE_RESET     = 4'h7;
  localparam logic [3:0] WDL_PRE_MAX_TIMED = 4'h7;
  localparam logic [3:0] WDL_PRE_AUTO_RST  = 4'h8;
  localparam logic [3:0] WDL_PRE_DL_RST    = 4'h9;
  localparam logic       WDL_EN_RESET      = 1'b1;
  localparam logic       WDL_RESP_RESET    = 1'b0;
  localparam logic       WDL_FLAG_RESET    = 1'b0;
  localparam logic [6:0] WDL_KEY_LOW_DEFAULT = 7'h7f;
  localparam logic [7:0] WDL_KEY_ERASED      = 8'hff;

  // ----------------------------------------------------------------------
  // timing: timeout = 2^pre * 2^9 crystal periods
  // ----------------------------------------------------------------------
  localparam int WDL_XTAL_HZ    = 32768;
  localparam int WDL_BASE_SHIFT = 9;

  // ----------------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       bit_wr;
    logic       bit_val;
    logic       rd;
  } wdl_sfr_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        wr;
  } wdl_flash_wr_t;

  typedef enum logic [1:0] {
    WDL_IDLE   = 2'b00,
    WDL_RUN    = 2'b01,
    WDL_EXPIRE = 2'b10
  } wdl_state_t;

  typedef enum logic {
    WDL_PG_IDLE  = 1'b0,
    WDL_PG_WRITE = 1'b1
  } wdl_pg_state_t;
endpackage

// ==== verilog/wdl_sync_edge.sv ====
/*
  Two-flop synchroniser with a rising-edge pulse for the crystal clock pin.
  Assumes the pin toggles much slower than core_clk.
*/
`timescale 1ns/1ps
module wdl_sync_edge (
  input  logic core_clk,
  input  logic reset_n,
  input  logic async_in,
  output logic rise
);
  logic meta;
  logic sync;
  logic sync_d;

  // ----------------------------------------------------------------------
  // synchroniser and edge detect
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta   <= 1'b0;
      sync   <= 1'b0;
      sync_d <= 1'b0;
      rise   <= 1'b0;
    end else begin
      meta   <= async_in;
      sync   <= meta;
      sync_d <= sync;
      rise   <= sync & ~sync_d;
    end
  end
endmodule // wdl_sync_edge

// ==== verilog/wdl_prot_prog.sv ====
/*
  Key compare and flash programming of the protection bytes.
  Assumes the flash controller takes one byte write per cycle.
*/
`timescale 1ns/1ps
module wdl_prot_prog import wdl_pkg::*; (
  input  logic          core_clk,
  input  logic          reset_n,
  input  logic          prot_req,
  input  logic [7:0]    stored_lock,
  input  logic [7:0]    key_reg,
  input  logic [39:0]   prot_new,
  output wdl_flash_wr_t flash_wr,
  output logic          prot_busy,
  output logic          key_mismatch
);
  wdl_pg_state_t pg;
  logic [2:0]    step;
  logic [39:0]   data_q;
  logic          match;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  assign match     = (stored_lock == key_reg);  // [R15]
  assign prot_busy = (pg == WDL_PG_WRITE);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pg           <= WDL_PG_IDLE;
      step         <= 3'h0;
      data_q       <= 40'h0;
      flash_wr     <= '0;
      key_mismatch <= 1'b0;
    end else begin
      flash_wr.wr  <= 1'b0;
      key_mismatch <= 1'b0;
      case (pg)
        WDL_PG_IDLE: begin
          if (prot_req && match) begin  // [R16]
            data_q <= prot_new;
            step   <= 3'h0;
            pg     <= WDL_PG_WRITE;
          end else if (prot_req) begin
            key_mismatch <= 1'b1;
          end
        end
        WDL_PG_WRITE: begin
          flash_wr.wr   <= 1'b1;  // [R16]
          flash_wr.addr <= WDL_FLASH_PROT_FIRST + 16'(step);
          flash_wr.data <= data_q[{step, 3'b000} +: 8];
          if (step == WDL_PROT_LAST_STEP) begin
            pg <= WDL_PG_IDLE;
          end else begin
            step <= step + 3'h1;
          end
        end
        default: pg <= WDL_PG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_key_gate: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R15]
    (prot_req && !prot_busy && !match) |=> (!prot_busy && key_mismatch))
    else $error("protection write started without key match");
  a_write_range: assert property (@(posedge core_clk) disable iff (!reset_n)  // [R16]
    flash_wr.wr |-> (flash_wr.addr >= WDL_FLASH_PROT_FIRST &&
                     flash_wr.addr <= WDL_FLASH_PROT_LAST))
    else $error("protection write outside its flash range");
  c_prog_run: cover property (@(posedge core_clk) disable iff (!reset_n)
    prot_req && match && !prot_busy);
endmodule // wdl_prot_prog

// ==== verilog/wdl_watchdog.sv ====
/*
  Watchdog timer with control register, write unlock and flash-held lock.
  Assumes an 8-bit register port on core_clk, the crystal clock on a pin,
  and the lock byte presented as a steady level by the flash controller.
*/
// What this block does
// R01: code 1000 resets at once; 0111 two seconds
// R02: code 1001 resets at once into download
// R03: software never programs codes 1010 to 1111
// R04: response bit clear: expiry gives system reset
// R05: response bit set: expiry gives interrupt
// R06: every timeout sets the timeout flag
// R07: flag cleared only by zero write, pin reset
// R08: watchdog reset leaves the timeout flag set
// R09: enable bit, default one, enables and clears counter
// R10: each later enable write clears counter again
// R11: lock active ignores enable and response writes
// R12: lock forces response zero and enable one
// R13: lock still accepts timeout select writes
// R14: default key is lock bit over 7f
// R15: compare stored key byte with key register
// R16: on match write bytes 3ffb to 3fff
// R17: counter on crystal; timeout 2^code times 512
// R18: unlock bit then very next write accepted
// R19: interrupt high priority, never masked globally
// R20: expiry on chosen counter bit, acted once
`timescale 1ns/1ps
module wdl_watchdog import wdl_pkg::*; #(
  parameter int CNT_W = 17
) (
  input  logic          core_clk,
  input  logic          reset_n,
  input  logic          xtal_clk_pin,
  input  wdl_sfr_req_t  sfr_req,
  output logic [7:0]    sfr_rdata,
  output logic          sfr_rsel,
  input  logic [7:0]    flash_lock_byte,
  input  logic [7:0]    protection_key,
  input  logic          prot_req,
  input  logic [39:0]   prot_new,
  output wdl_flash_wr_t flash_wr,
  output logic          prot_busy,
  output logic          key_mismatch,
  output logic [7:0]    default_key,
  output logic          wdt_sys_rst,
  output logic          wdt_dl_rst,
  output logic          wdt_irq
);
  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  if (CNT_W < WDL_BASE_SHIFT + int'(WDL_PRE_MAX_TIMED) + 1) begin : g_bad_width
    $error("CNT_W too narrow for the longest timeout");
  end

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  wdl_state_t       state;
  wdl_state_t       next_state;
  logic [CNT_W-1:0] cnt;
  logic [3:0]       pre_q;
  logic             en_q;
  logic             resp_q;
  logic             flag_q;
  logic             armed;
  logic             lock_active;
  logic             en_eff;
  logic             resp_eff;
  logic             tick;
  logic             any_wr;
  logic             hit_byte;
  logic             hit_bit;
  logic             ctrl_wr;
  logic             ctrl_acc;
  logic             kick;
  logic [7:0]       cur_byte;
  logic [7:0]       new_byte;
  logic             sel_hit;
  logic             is_auto;
  logic             is_dl;
  logic             fire_rst;
  logic             fire_irq;

  // ----------------------------------------------------------------------
  // crystal tick and protection programming
  // ----------------------------------------------------------------------
  wdl_sync_edge u_xtal (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (xtal_clk_pin),
    .rise     (tick)
  );

  wdl_prot_prog u_prog (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .prot_req     (prot_req),
    .stored_lock  (flash_lock_byte),
    .key_reg      (protection_key),
    .prot_new     (prot_new),
    .flash_wr     (flash_wr),
    .prot_busy    (prot_busy),
    .key_mismatch (key_mismatch)
  );

  // ----------------------------------------------------------------------
  // lock and effective settings
  // ----------------------------------------------------------------------
  assign lock_active = ~flash_lock_byte[WDL_LOCK_BIT];  // [R11]
  assign en_eff      = en_q | lock_active;              // [R12]
  assign resp_eff    = resp_q & ~lock_active;           // [R12]

  // ----------------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------------
  assign any_wr   = sfr_req.wr | sfr_req.bit_wr;
  assign hit_byte = sfr_req.wr && (sfr_req.addr == WDL_CTRL_ADDR);
  assign hit_bit  = sfr_req.bit_wr && (sfr_req.addr[7:3] == WDL_CTRL_ADDR[7:3]);
  assign ctrl_wr  = hit_byte | hit_bit;
  assign ctrl_acc = armed & ctrl_wr;             // [R18]
  assign kick     = ctrl_acc & new_byte[WDL_BIT_EN];  // [R10]

  always_comb begin
    cur_byte = {pre_q, resp_eff, flag_q, en_eff, armed};
    new_byte = sfr_req.wdata;
    if (hit_bit) begin
      new_byte = cur_byte;
      new_byte[sfr_req.addr[2:0]] = sfr_req.bit_val;
    end
  end

  // unlock arms on a write setting the unlock bit; next write consumes it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      armed <= 1'b0;
    end else if (fire_rst) begin
      armed <= 1'b0;
    end else if (armed && any_wr) begin
      armed <= 1'b0;  // [R18]
    end else if (ctrl_wr && new_byte[WDL_BIT_UNLOCK]) begin
      armed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n || fire_rst) begin
      pre_q <= WDL_PRE_RESET;
    end else if (ctrl_acc) begin
      pre_q <= new_byte[7:4];  // [R13]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n || fire_rst) begin
      en_q   <= WDL_EN_RESET;    // [R09]
      resp_q <= WDL_RESP_RESET;
    end else if (ctrl_acc && !lock_active) begin  // [R11]
      en_q   <= new_byte[WDL_BIT_EN];
      resp_q <= new_byte[WDL_BIT_RESP];
    end
  end

  // a watchdog reset does not clear the flag; the set wins over a clear
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      flag_q <= WDL_FLAG_RESET;  // [R07]
    end else if (state == WDL_EXPIRE) begin
      flag_q <= 1'b1;            // [R06] [R08]
    end else if (ctrl_acc && !new_byte[WDL_BIT_FLAG]) begin
      flag_q <= 1'b0;            // [R07]
    end
  end

  // ----------------------------------------------------------------------
  // counter and expiry detect
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt <= '0;
    end else if (fire_rst || kick || state == WDL_EXPIRE || !en_eff) begin
      cnt <= '0;  // [R09] [R10]
    end else if (tick) begin
      cnt <= cnt + CNT_W'(1);  // [R17]
    end
  end

  assign is_auto = (pre_q == WDL_PRE_AUTO_RST);
  assign is_dl   = (pre_q == WDL_PRE_DL_RST);

  // invalid codes never expire
  always_comb begin
    sel_hit = 1'b0;
    if (pre_q <= WDL_PRE_MAX_TIMED) begin
      sel_hit = cnt[{1'b0, pre_q} + 5'(WDL_BASE_SHIFT)];  // [R17] [R20]
    end else if (is_auto || is_dl) begin
      sel_hit = 1'b1;  // [R01] [R02]
    end
  end

  // ----------------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      WDL_IDLE: begin
        if (en_eff) begin
          next_state = WDL_RUN;
        end
      end
      WDL_RUN: begin
        if (!en_eff) begin
          next_state = WDL_IDLE;
        end else if (!kick && sel_hit) begin
          next_state = WDL_EXPIRE;  // [R20]
        end
      end
      WDL_EXPIRE: begin
        next_state = en_eff ? WDL_RUN : WDL_IDLE;
      end
      default: next_state = WDL_IDLE;
    endcase
    if (fire_rst) begin
      next_state = WDL_RUN;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= WDL_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // expiry response
  // ----------------------------------------------------------------------
  assign fire_rst = (state == WDL_EXPIRE) && (is_auto || is_dl || !resp_eff);  // [R04]
  assign fire_irq = (state == WDL_EXPIRE) && !fire_rst;                       // [R05]

  // the interrupt is not gated by any global enable
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wdt_sys_rst <= 1'b0;
      wdt_dl_rst  <= 1'b0;
      wdt_irq     <= 1'b0;
    end else begin
      wdt_sys_rst <= fire_rst & ~is_dl;  // [R01] [R04]
      wdt_dl_rst  <= fire_rst & is_dl;   // [R02]
      wdt_irq     <= fire_irq;           // [R19]
    end
  end

  // ----------------------------------------------------------------------
  // read back and default key
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sfr_rsel  <= 1'b0;
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rsel  <= sfr_req.rd && (sfr_req.addr == WDL_CTRL_ADDR);
      sfr_rdata <= (sfr_req.rd && sfr_req.addr == WDL_CTRL_ADDR) ? cur_byte : 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      default_key <= WDL_KEY_ERASED;
    end else begin
      default_key <= {flash_lock_byte[WDL_LOCK_BIT], WDL_KEY_LOW_DEFAULT};  // [R14]
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_code8_reset: assert property (  // [R01]
    (state == WDL_EXPIRE && is_auto) |=> (wdt_sys_rst && !wdt_irq && !wdt_dl_rst))
    else $error("code 1000 did not give a system reset");
  a_code9_dl: assert property (  // [R02]
    (state == WDL_EXPIRE && is_dl) |=> (wdt_dl_rst && !wdt_sys_rst))
    else $error("code 1001 did not give a download reset");
  a_resp_reset: assert property (  // [R04]
    (state == WDL_EXPIRE && pre_q <= WDL_PRE_MAX_TIMED && !resp_eff)
      |=> (wdt_sys_rst && !wdt_irq) ##1 !wdt_sys_rst)
    else $error("reset response missing or not a single pulse");
  a_resp_irq: assert property (  // [R05]
    (state == WDL_EXPIRE && pre_q <= WDL_PRE_MAX_TIMED && resp_eff)
      |=> (wdt_irq && !wdt_sys_rst))
    else $error("interrupt response missing");
  a_flag_set: assert property (  // [R06]
    (state == WDL_EXPIRE) |=> flag_q)
    else $error("timeout flag not set on expiry");
  a_flag_hold: assert property (  // [R07] [R08]
    (flag_q && !(ctrl_acc && !new_byte[WDL_BIT_FLAG])) |=> flag_q)
    else $error("timeout flag lost without a zero write");
  a_kick_clear: assert property (  // [R10]
    kick |=> (cnt == '0))
    else $error("enable write did not clear the counter");
  a_lock_ignore: assert property (  // [R11]
    (lock_active && ctrl_acc && !fire_rst) |=> ($stable(en_q) && $stable(resp_q)))
    else $error("locked enable or response changed");
  a_lock_force: assert property (  // [R12]
    (lock_active && sfr_req.rd && sfr_req.addr == WDL_CTRL_ADDR)
      |=> (sfr_rdata[WDL_BIT_EN] && !sfr_rdata[WDL_BIT_RESP]))
    else $error("lock did not force enable and response");
  a_lock_pre: assert property (  // [R13]
    (lock_active && ctrl_acc && !fire_rst) |=> (pre_q == $past(new_byte[7:4])))
    else $error("timeout select write refused under lock");
  a_key_value: assert property (  // [R14]
    ##1 (default_key == {$past(flash_lock_byte[WDL_LOCK_BIT]), WDL_KEY_LOW_DEFAULT}))
    else $error("default key does not follow lock bit");
  a_expire_once: assert property (  // [R20]
    (state == WDL_EXPIRE) |=> (state != WDL_EXPIRE && cnt == '0))
    else $error("expiry acted on more than once");
  a_unarmed_ignore: assert property (  // [R18]
    (ctrl_wr && !armed && !fire_rst) |=> ($stable(pre_q) && $stable(en_q) && $stable(resp_q)))
    else $error("write without unlock changed the control fields");
  a_disabled_hold: assert property (  // [R09]
    !en_eff |=> (cnt == '0))
    else $error("counter moved while disabled");
  a_flag_clear: assert property (  // [R07]
    (ctrl_acc && !new_byte[WDL_BIT_FLAG] && state != WDL_EXPIRE) |=> !flag_q)
    else $error("zero write did not clear the timeout flag");
  a_irq_ungated: assert property (  // [R19]
    fire_irq |=> (wdt_irq && !wdt_sys_rst && !wdt_dl_rst))
    else $error("interrupt response blocked");
  a_wdt_reload: assert property (  // [R08] [R09]
    fire_rst |=> (en_q && !resp_q && pre_q == WDL_PRE_RESET && flag_q))
    else $error("watchdog reset did not reload the control fields");

  c_reset_expiry: cover property (state == WDL_EXPIRE && !resp_eff && !is_dl);
  c_irq_expiry:   cover property (fire_irq ##1 wdt_irq);
  c_dl_reset:     cover property (wdt_dl_rst);
  c_kick:         cover property (kick && cnt != '0);
endmodule // wdl_watchdog

// ==== verification/wdl_watchdog_tb.sv ====
/*
  Self-checking testbench for the watchdog with flash lock.
  Assumes the design package is compiled first; the crystal pin is toggled
  every 4 core cycles so that timeouts fit a short run.
*/
`timescale 1ns/1ps
module wdl_watchdog_tb import wdl_pkg::*; ;
  // --------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------
  logic          core_clk;
  logic          reset_n;
  logic          xtal_clk_pin;
  wdl_sfr_req_t  req;
  logic [7:0]    rdata;
  logic          rsel;
  logic [7:0]    lock_byte;
  logic [7:0]    key;
  logic          prot_req;
  logic [39:0]   prot_new;
  wdl_flash_wr_t fwr;
  logic          busy;
  logic          mism;
  logic [7:0]    dkey;
  logic          sys_rst;
  logic          dl_rst;
  logic          irq;
  int            miscompares;
  int            check_count;
  int            cyc;
  int            nwr;
  logic [2:0]    seen;
  logic          mm;
  logic          bz;

  wdl_watchdog #(.CNT_W(17)) dut (
    .core_clk        (core_clk),
    .reset_n         (reset_n),
    .xtal_clk_pin    (xtal_clk_pin),
    .sfr_req         (req),
    .sfr_rdata       (rdata),
    .sfr_rsel        (rsel),
    .flash_lock_byte (lock_byte),
    .protection_key  (key),
    .prot_req        (prot_req),
    .prot_new        (prot_new),
    .flash_wr        (fwr),
    .prot_busy       (busy),
    .key_mismatch    (mism),
    .default_key     (dkey),
    .wdt_sys_rst     (sys_rst),
    .wdt_dl_rst      (dl_rst),
    .wdt_irq         (irq)
  );

  // --------------------------------------------------------------------
  // clocks
  // --------------------------------------------------------------------
  always #20 core_clk = ~core_clk;

  always begin
    repeat (4) @(negedge core_clk);
    xtal_clk_pin = ~xtal_clk_pin;
  end

  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_win(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge core_clk);
    req.wr = 1'b0;
  endtask

  task automatic sfr_bit(input logic [7:0] a, input logic v);
    @(negedge core_clk);
    req.addr = a;
    req.bit_val = v;
    req.bit_wr = 1'b1;
    @(negedge core_clk);
    req.bit_wr = 1'b0;
  endtask

  // arm with the unlock bit, then the write that counts
  task automatic unl_wr(input logic [7:0] d);
    sfr_wr(WDL_CTRL_ADDR, 8'h01);
    // callers pass only timeout codes 0000 to 1001 in the top nibble
    sfr_wr(WDL_CTRL_ADDR, d);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] exp);
    @(negedge core_clk);
    req.addr = WDL_CTRL_ADDR;
    req.rd = 1'b1;
    @(negedge core_clk);
    req.rd = 1'b0;
    // the registered answer stands for this one cycle only
    check("read select", 16'h0001, 16'(rsel));
    check(what, 16'(exp), 16'(rdata));
  endtask

  // seen holds {download reset, system reset, interrupt}
  task automatic wait_pulse(input int max);
    seen = 3'b000;
    cyc = 0;
    while (seen == 3'b000 && cyc < max) begin
      @(negedge core_clk);
      cyc++;
      seen = {dl_rst, sys_rst, irq};
    end
  endtask

  task automatic prot_run;
    nwr = 0;
    mm = 1'b0;
    bz = 1'b0;
    @(negedge core_clk);
    prot_req = 1'b1;
    repeat (12) begin
      @(negedge core_clk);
      prot_req = 1'b0;
      if (mism === 1'b1) mm = 1'b1;
      if (busy === 1'b1) bz = 1'b1;
      if (fwr.wr === 1'b1 && nwr < 5) begin
        check("flash addr", WDL_FLASH_PROT_FIRST + 16'(nwr), fwr.addr);
        check("flash data", 16'(prot_new[8*nwr +: 8]), 16'(fwr.data));
      end
      if (fwr.wr === 1'b1) nwr++;
    end
  endtask

  // --------------------------------------------------------------------
  // watchdog on the run
  // --------------------------------------------------------------------
  initial begin
    #(80000 * 40);
    miscompares++;
    $display("Error run time expected end seen hang");
    end_sim();
  end

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    xtal_clk_pin = 1'b0;
    req = '0;
    lock_byte = 8'hff;
    key = 8'h12;
    prot_req = 1'b0;
    prot_new = 40'h5544332211;
    miscompares = 0;
    check_count = 0;
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    rd_chk("ctrl after reset", 8'h72);
    check("default key", 16'h00ff, 16'(dkey));
    sfr_wr(WDL_CTRL_ADDR, 8'h00);
    rd_chk("ctrl unarmed write", 8'h72);
    sfr_wr(WDL_CTRL_ADDR, 8'h01);
    sfr_wr(8'h80, 8'h00);
    sfr_wr(WDL_CTRL_ADDR, 8'h00);
    rd_chk("ctrl disarmed write", 8'h72);
    unl_wr(8'h76);
    rd_chk("flag written one", 8'h72);
    unl_wr(8'h00);
    rd_chk("ctrl disabled", 8'h00);
    wait_pulse(5000);
    check("pulses disabled", 16'h0000, 16'(seen));
    unl_wr(8'h02);
    wait_pulse(3000);
    check("pulses before kick", 16'h0000, 16'(seen));
    sfr_bit(WDL_CTRL_ADDR, 1'b1);
    sfr_bit(8'hc1, 1'b1);
    wait_pulse(6000);
    check("pulses reset mode", 16'h0002, 16'(seen));
    check_win("timeout code 0", 4080, 4120, cyc);
    rd_chk("ctrl after wdt reset", 8'h76);
    unl_wr(8'h1a);
    rd_chk("ctrl irq mode", 8'h1a);
    wait_pulse(10000);
    check("pulses irq mode", 16'h0001, 16'(seen));
    check_win("timeout code 1", 8176, 8216, cyc);
    wait_pulse(10000);
    check("pulses irq repeat", 16'h0001, 16'(seen));
    check_win("period code 1", 8176, 8216, cyc);
    rd_chk("ctrl after irq", 8'h1e);
    unl_wr(8'h82);
    wait_pulse(10);
    check("pulses code 8", 16'h0002, 16'(seen));
    rd_chk("ctrl after code 8", 8'h76);
    unl_wr(8'h92);
    wait_pulse(10);
    check("pulses code 9", 16'h0004, 16'(seen));
    lock_byte = 8'h7f;
    repeat (2) @(negedge core_clk);
    check("default key locked", 16'h007f, 16'(dkey));
    unl_wr(8'h38);
    rd_chk("ctrl locked write", 8'h32);
    unl_wr(8'h08);
    rd_chk("ctrl locked irq", 8'h02);
    wait_pulse(5000);
    check("pulses locked", 16'h0002, 16'(seen));
    lock_byte = 8'hff;
    prot_run();
    check("key mismatch", 16'h0001, 16'(mm));
    check("writes on mismatch", 16'h0000, 16'(nwr));
    key = 8'hff;
    prot_run();
    check("key match", 16'h0000, 16'(mm));
    check("busy on match", 16'h0001, 16'(bz));
    check("writes on match", 16'h0005, 16'(nwr));
    reset_n = 1'b0;
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    rd_chk("ctrl after pin reset", 8'h72);
    end_sim();
  end
endmodule // wdl_watchdog_tb
